//--- pia_pkg.sv
// pia_pkg: constants and types for the priority interrupt arbiter
// assumes a single 250 MHz core clock and an APB register bus
`default_nettype none
package pia_pkg;
  localparam int NSRC = 13;
  localparam int SRC_W = 4;
  localparam int LVL_W = 3;
  localparam int ADDR_W = 12;

  // register indices; byte address is four times the index, so offsets are word aligned
  localparam logic [7:0] IDX_EXT_FLAGS = 8'h91;
  localparam logic [7:0] IDX_WD_PWR = 8'hD8;
  localparam logic [7:0] IDX_EXT_EN = 8'hE8;
  localparam logic [7:0] IDX_BASE_EN = 8'hA8;
  localparam logic [7:0] IDX_PRIO_LOW = 8'hB8;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hB9;
  localparam logic [7:0] IDX_EPRIO_LOW = 8'hF8;
  localparam logic [7:0] IDX_EPRIO_HIGH = 8'hF9;
  localparam logic [7:0] IDX_TCTRL = 8'h88;
  localparam logic [7:0] IDX_STATUS = 8'hC0;

  // field positions
  localparam int B_GLOBAL = 7;
  localparam int B_IT0 = 0;
  localparam int B_PIN0_FLAG = 1;
  localparam int B_IT1 = 2;
  localparam int B_PIN1_FLAG = 3;
  localparam int B_TMR0_FLAG = 5;
  localparam int B_TMR1_FLAG = 7;
  localparam int B_WDOG_FLAG = 3;
  localparam int B_SUPPLY_FLAG = 4;
  localparam int B_SUPPLY_EN = 5;
  localparam int B_PIN2_FLAG = 4;

  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [LVL_W-1:0] LVL_PFAIL = 3'h4;
  localparam logic [LVL_W-1:0] LVL_IDLE = 3'h7;

  localparam logic [7:0] VEC_TABLE [NSRC] = '{8'h33, 8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
    8'h2B, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};

  typedef enum logic [SRC_W-1:0] {
    S_PFAIL, S_EXT0, S_TMR0, S_EXT1, S_TMR1, S_SER0, S_TMR2,
    S_SER1, S_EXT2, S_EXT3, S_EXT4, S_EXT5, S_WDOG
  } pia_src_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    logic [LVL_W-1:0] level;
    logic [SRC_W-1:0] source;
  } pia_req_t;
endpackage : pia_pkg
`default_nettype wire

//--- pia_arbiter.sv
// pia_arbiter: collects thirteen requests, ranks them and vectors the core
// assumes peripheral event inputs are one-cycle pulses on clk_sys_i; pins are async
//
// Behaviour
// - five levels, rank by level first
// - supply failure level 4, always wins
// - other sources programmable levels three to zero
// - ties broken by fixed natural order
// - flags set regardless of enable bits
// - edge pin 0/1 flags cleared on vector
// - level pin 0/1 flags follow pin
// - timer 0/1 overflow cleared on vector
// - pin 0 vector 03h, position 1
// - timer 0 vector 0Bh, position 2
// - pin 1 vector 13h, position 3
// - timer 1 vector 1Bh, position 4
// - serial 0 rx or tx shares 23h
// - timer 2 overflow or trigger shares 2Bh
// - serial 1 rx or tx shares 3Bh
// - pin 2 extended flag, enable, 43h
// - pin 3 extended priority bits, 4Bh
// - pin 4 extended flag, enable, 53h
// - pin 5 flag bit 7, 5Bh
// - watchdog flag bit 3, 63h lowest
`timescale 1ns/100ps
`default_nettype none
module pia_arbiter
  import pia_pkg::*;
#(
  parameter int NEST = 5
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // external pins, asynchronous
  input  wire logic [5:0]        ext_pin_n_i,
  // peripheral events, core clock
  input  wire logic              supply_fail_evt_i,
  input  wire logic              timer0_ovf_evt_i,
  input  wire logic              timer1_ovf_evt_i,
  input  wire logic              serial0_rx_done_i,
  input  wire logic              serial0_tx_done_i,
  input  wire logic              timer2_ovf_evt_i,
  input  wire logic              timer2_trig_evt_i,
  input  wire logic              serial1_rx_done_i,
  input  wire logic              serial1_tx_done_i,
  input  wire logic              watchdog_evt_i,
  // core handshake
  input  wire logic              vector_ack_i,
  input  wire logic              reti_i,
  output logic                   irq_req_o,
  output logic [7:0]             irq_vector_o,
  output logic [LVL_W-1:0]       active_level_o
);

  // registers
  logic [7:0] base_en, prio_low, prio_high, eprio_low, eprio_high, ext_en;
  logic [7:0] tctrl, ext_flags, wd_pwr;
  logic [7:0] ser_flags;
  logic [7:0] next_base_en, next_prio_low, next_prio_high, next_eprio_low;
  logic [7:0] next_eprio_high, next_ext_en, next_tctrl, next_ext_flags, next_wd_pwr;
  logic [7:0] next_ser_flags;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;

  // pin synchronisers: three stages, change accepted when stages two and three agree
  logic [5:0] pin_s1, pin_s2, pin_s3, pin_lvl, next_pin_lvl;
  logic [5:0] pin_fall;

  // service nesting stack of levels
  logic [LVL_W-1:0] stk [NEST];
  logic [LVL_W-1:0] next_stk [NEST];
  logic [2:0]       depth, next_depth;
  logic             next_irq_req;
  logic [7:0]       next_vector;
  logic [LVL_W-1:0] next_active;
  // source of the offered vector: the clear must hit what the core took, not a later winner
  logic [SRC_W-1:0] offer_src, next_offer;

  pia_req_t   win;
  logic [NSRC-1:0] pend;
  logic [LVL_W-1:0] lvl [NSRC];
  logic       taken;
  logic [SRC_W-1:0] ack_src;

  function automatic logic [LVL_W-1:0] lvl_of(input logic hi, input logic lo);
    lvl_of = {1'b0, hi, lo};
  endfunction : lvl_of

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction : hit

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1 <= 6'h3F;
      pin_s2 <= 6'h3F;
      pin_s3 <= 6'h3F;
      pin_lvl <= 6'h00;
    end else begin
      pin_s1 <= ext_pin_n_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  always_comb begin
    next_pin_lvl = pin_lvl;
    for (int i = 0; i < 6; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_lvl[i] = ~pin_s3[i];
      end
    end
    pin_fall = next_pin_lvl & ~pin_lvl;
  end

  // pending vector in natural order
  always_comb begin
    pend = '0;
    pend[S_PFAIL] = wd_pwr[B_SUPPLY_FLAG] & wd_pwr[B_SUPPLY_EN];
    pend[S_EXT0] = tctrl[B_PIN0_FLAG] & base_en[0];
    pend[S_TMR0] = tctrl[B_TMR0_FLAG] & base_en[1];
    pend[S_EXT1] = tctrl[B_PIN1_FLAG] & base_en[2];
    pend[S_TMR1] = tctrl[B_TMR1_FLAG] & base_en[3];
    pend[S_SER0] = (ser_flags[0] | ser_flags[1]) & base_en[4];
    pend[S_TMR2] = (ser_flags[4] | ser_flags[5]) & base_en[5];
    pend[S_SER1] = (ser_flags[2] | ser_flags[3]) & base_en[6];
    pend[S_EXT2] = ext_flags[4] & ext_en[0];
    pend[S_EXT3] = ext_flags[5] & ext_en[1];
    pend[S_EXT4] = ext_flags[6] & ext_en[2];
    pend[S_EXT5] = ext_flags[7] & ext_en[3];
    pend[S_WDOG] = wd_pwr[B_WDOG_FLAG] & ext_en[4];
    lvl[0] = LVL_PFAIL;
    for (int i = 1; i < 8; i++) begin
      lvl[i] = lvl_of(prio_high[i-1], prio_low[i-1]);
    end
    for (int i = 8; i < NSRC; i++) begin
      lvl[i] = lvl_of(eprio_high[i-8], eprio_low[i-8]);
    end
  end

  // highest level wins; strict compare keeps the earliest position on a tie
  always_comb begin
    win = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (pend[i] && (!win.valid || lvl[i] > win.level)) begin
        win.valid = 1'b1;
        win.level = lvl[i];
        win.source = SRC_W'(i);
        win.vector = VEC_TABLE[i];
      end
    end
  end

  // service stack; a request that equals the running level waits
  always_comb begin
    logic [LVL_W-1:0] cur;
    cur = (depth == 3'h0) ? LVL_IDLE : stk[depth - 3'h1];
    next_stk = stk;
    next_depth = depth;
    taken = vector_ack_i & irq_req_o;
    ack_src = '0;
    if (taken && depth < 3'(NEST)) begin
      next_stk[depth] = active_level_o;
      next_depth = depth + 3'h1;
      ack_src = offer_src;
    end else if (reti_i && depth != 3'h0) begin
      next_depth = depth - 3'h1;
    end
    cur = (next_depth == 3'h0) ? LVL_IDLE : next_stk[next_depth - 3'h1];
    next_irq_req = base_en[B_GLOBAL] && win.valid &&
                   (cur == LVL_IDLE || win.level > cur) && !taken;
    next_vector = win.vector;
    next_active = win.level;
    next_offer = win.source;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      depth <= 3'h0;
      irq_req_o <= 1'b0;
      irq_vector_o <= 8'h00;
      active_level_o <= 3'h0;
      offer_src <= '0;
      for (int i = 0; i < NEST; i++) begin
        stk[i] <= 3'h0;
      end
    end else begin
      depth <= next_depth;
      irq_req_o <= next_irq_req;
      irq_vector_o <= next_vector;
      active_level_o <= next_active;
      offer_src <= next_offer;
      stk <= next_stk;
    end
  end

  // register file and flags; hardware sets win over software clears
  always_comb begin
    logic wr, rd;
    wr = psel_i & penable_i & pwrite_i;
    rd = psel_i & penable_i & ~pwrite_i;
    next_base_en = base_en;
    next_prio_low = prio_low;
    next_prio_high = prio_high;
    next_eprio_low = eprio_low;
    next_eprio_high = eprio_high;
    next_ext_en = ext_en;
    next_tctrl = tctrl;
    next_ext_flags = ext_flags;
    next_wd_pwr = wd_pwr;
    next_ser_flags = ser_flags;
    next_prdata = 32'h0;
    next_pready = psel_i & penable_i & ~pready_o;
    next_pslverr = 1'b0;
    if (wr && !pready_o) begin
      if (hit(paddr_i, IDX_BASE_EN)) begin
        next_base_en = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_PRIO_LOW)) begin
        next_prio_low = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_PRIO_HIGH)) begin
        next_prio_high = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_EPRIO_LOW)) begin
        next_eprio_low = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_EPRIO_HIGH)) begin
        next_eprio_high = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_EXT_EN)) begin
        next_ext_en = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_TCTRL)) begin
        next_tctrl = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_EXT_FLAGS)) begin
        next_ext_flags = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_WD_PWR)) begin
        next_wd_pwr = pwdata_i[7:0];
      end else if (hit(paddr_i, IDX_STATUS)) begin
        next_ser_flags = pwdata_i[7:0];
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (rd && !pready_o) begin
      if (hit(paddr_i, IDX_BASE_EN)) begin
        next_prdata[7:0] = base_en;
      end else if (hit(paddr_i, IDX_PRIO_LOW)) begin
        next_prdata[7:0] = prio_low;
      end else if (hit(paddr_i, IDX_PRIO_HIGH)) begin
        next_prdata[7:0] = prio_high;
      end else if (hit(paddr_i, IDX_EPRIO_LOW)) begin
        next_prdata[7:0] = eprio_low;
      end else if (hit(paddr_i, IDX_EPRIO_HIGH)) begin
        next_prdata[7:0] = eprio_high;
      end else if (hit(paddr_i, IDX_EXT_EN)) begin
        next_prdata[7:0] = ext_en;
      end else if (hit(paddr_i, IDX_TCTRL)) begin
        next_prdata[7:0] = tctrl;
      end else if (hit(paddr_i, IDX_EXT_FLAGS)) begin
        next_prdata[7:0] = ext_flags;
      end else if (hit(paddr_i, IDX_WD_PWR)) begin
        next_prdata[7:0] = wd_pwr;
      end else if (hit(paddr_i, IDX_STATUS)) begin
        next_prdata = {16'h0, 5'h0, active_level_o, ser_flags};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    // automatic clears on vector entry
    if (taken) begin
      if (ack_src == S_EXT0 && tctrl[B_IT0]) begin
        next_tctrl[B_PIN0_FLAG] = 1'b0;
      end
      if (ack_src == S_EXT1 && tctrl[B_IT1]) begin
        next_tctrl[B_PIN1_FLAG] = 1'b0;
      end
      if (ack_src == S_TMR0) begin
        next_tctrl[B_TMR0_FLAG] = 1'b0;
      end
      if (ack_src == S_TMR1) begin
        next_tctrl[B_TMR1_FLAG] = 1'b0;
      end
    end
    // pin 0/1: edge latches, level mode follows the pin
    if (tctrl[B_IT0]) begin
      if (pin_fall[0]) begin
        next_tctrl[B_PIN0_FLAG] = 1'b1;
      end
    end else begin
      next_tctrl[B_PIN0_FLAG] = pin_lvl[0];
    end
    if (tctrl[B_IT1]) begin
      if (pin_fall[1]) begin
        next_tctrl[B_PIN1_FLAG] = 1'b1;
      end
    end else begin
      next_tctrl[B_PIN1_FLAG] = pin_lvl[1];
    end
    if (timer0_ovf_evt_i) begin
      next_tctrl[B_TMR0_FLAG] = 1'b1;
    end
    if (timer1_ovf_evt_i) begin
      next_tctrl[B_TMR1_FLAG] = 1'b1;
    end
    for (int i = 2; i < 6; i++) begin
      if (pin_fall[i]) begin
        next_ext_flags[B_PIN2_FLAG + i - 2] = 1'b1;
      end
    end
    if (supply_fail_evt_i) begin
      next_wd_pwr[B_SUPPLY_FLAG] = 1'b1;
    end
    if (watchdog_evt_i) begin
      next_wd_pwr[B_WDOG_FLAG] = 1'b1;
    end
    if (serial0_rx_done_i) begin
      next_ser_flags[0] = 1'b1;
    end
    if (serial0_tx_done_i) begin
      next_ser_flags[1] = 1'b1;
    end
    if (serial1_rx_done_i) begin
      next_ser_flags[2] = 1'b1;
    end
    if (serial1_tx_done_i) begin
      next_ser_flags[3] = 1'b1;
    end
    if (timer2_ovf_evt_i) begin
      next_ser_flags[4] = 1'b1;
    end
    if (timer2_trig_evt_i) begin
      next_ser_flags[5] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      base_en <= REG_RST;
      prio_low <= REG_RST;
      prio_high <= REG_RST;
      eprio_low <= REG_RST;
      eprio_high <= REG_RST;
      ext_en <= REG_RST;
      tctrl <= REG_RST;
      ext_flags <= REG_RST;
      wd_pwr <= REG_RST;
      ser_flags <= REG_RST;
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      base_en <= next_base_en;
      prio_low <= next_prio_low;
      prio_high <= next_prio_high;
      eprio_low <= next_eprio_low;
      eprio_high <= next_eprio_high;
      ext_en <= next_ext_en;
      tctrl <= next_tctrl;
      ext_flags <= next_ext_flags;
      wd_pwr <= next_wd_pwr;
      ser_flags <= next_ser_flags;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

endmodule : pia_arbiter
`default_nettype wire

//--- pia_core_model.sv
// pia_core_model: core side of the vector handshake
// assumes one clock; acks a standing request one cycle after seeing it unless held off
`timescale 1ns/100ps
`default_nettype none
module pia_core_model (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  // arbiter side
  input  wire logic       irq_req_i,
  input  wire logic [7:0] irq_vector_i,
  output logic            vector_ack_o,
  output logic [7:0]      taken_o,
  // bench control
  input  wire logic       hold_i
);
  logic       next_ack;
  logic [7:0] next_taken;
  // never acks two cycles running, so one request is taken once
  always_comb begin
    next_ack = irq_req_i && !hold_i && !vector_ack_o;
    next_taken = next_ack ? irq_vector_i : taken_o;
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vector_ack_o <= 1'b0;
      taken_o <= 8'h00;
    end else begin
      vector_ack_o <= next_ack;
      taken_o <= next_taken;
    end
  end
endmodule : pia_core_model
`default_nettype wire

//--- pia_arbiter_asserts.sv
// pia_arbiter_asserts: port checks on the arbiter, bound below
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module pia_arbiter_asserts
  import pia_pkg::*;
#(
  parameter int NEST = 5
) (
  // clock and reset
  input wire logic             clk_sys_i,
  input wire logic             nrst_i,
  // apb
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  // core
  input wire logic             vector_ack_i,
  input wire logic             irq_req_o,
  input wire logic [7:0]       irq_vector_o,
  input wire logic [LVL_W-1:0] active_level_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  property p_lvl_range; irq_req_o |-> active_level_o <= LVL_PFAIL; endproperty
  a_lvl_range: assert property (p_lvl_range) else $error("level above four");
  property p_pf_vec; irq_req_o && active_level_o == LVL_PFAIL |-> irq_vector_o == 8'h33; endproperty
  a_pf_vec: assert property (p_pf_vec) else $error("top level not supply vector");
  property p_pf_lvl; irq_req_o && irq_vector_o == 8'h33 |-> active_level_o == 3'h4; endproperty
  a_pf_lvl: assert property (p_pf_lvl) else $error("supply vector not top level");
  property p_oth_lvl; irq_req_o && irq_vector_o != 8'h33 |-> active_level_o <= 3'h3; endproperty
  a_oth_lvl: assert property (p_oth_lvl) else $error("source level above three");
  property p_vec_tab;
    irq_req_o |-> irq_vector_o inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33,
      8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63};
  endproperty
  a_vec_tab: assert property (p_vec_tab) else $error("vector outside table");
  property p_ack_drop; vector_ack_i && irq_req_o |=> !irq_req_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request stands after ack");
  property p_rdy; pready_o |-> psel_i && penable_i ##1 !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready outside one access cycle");
  property p_err; pslverr_o |-> pready_o; endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule : pia_arbiter_asserts
bind pia_arbiter pia_arbiter_asserts #(.NEST(NEST)) pia_arbiter_asserts_inst (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .vector_ack_i(vector_ack_i),
  .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .active_level_o(active_level_o));
`default_nettype wire

//--- pia_arbiter_test.sv
// pia_arbiter_test: self-checking bench for the priority interrupt arbiter
// assumes the core model acks offered vectors and the checker binds itself
`timescale 1ns/100ps
`default_nettype none
module pia_arbiter_test
  import pia_pkg::*;
;
  typedef struct packed {
    logic [3:0] k;
    logic [7:0] ei;
    logic [7:0] ev;
    logic [7:0] vec;
  } pia_row_t;
  logic              clk_sys_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              psel_i = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0]       pwdata_i = '0;
  logic [31:0]       prdata_o;
  logic              pready_o;
  logic              pslverr_o;
  logic [5:0]        pins_n = 6'h3F;
  logic [9:0]        evt = '0;
  logic              ack;
  logic              reti = 1'b0;
  logic              hold = 1'b0;
  logic              irq_req_o;
  logic [7:0]        irq_vector_o;
  logic [LVL_W-1:0]  active_level_o;
  logic [7:0]        taken;
  logic [31:0]       rd;
  logic              err;
  int                errors = 0;
  int                checked = 0;
  logic [7:0]        regs [6] = '{IDX_BASE_EN, IDX_EXT_EN, IDX_WD_PWR, IDX_TCTRL,
                                  IDX_EXT_FLAGS, IDX_STATUS};
  pia_row_t          rows [17] = '{
    '{4'h0, IDX_WD_PWR, 8'h20, 8'h33},
    '{4'hA, IDX_BASE_EN, 8'h81, 8'h03},
    '{4'h1, IDX_BASE_EN, 8'h82, 8'h0B},
    '{4'hB, IDX_BASE_EN, 8'h84, 8'h13},
    '{4'h2, IDX_BASE_EN, 8'h88, 8'h1B},
    '{4'h3, IDX_BASE_EN, 8'h90, 8'h23},
    '{4'h4, IDX_BASE_EN, 8'h90, 8'h23},
    '{4'h5, IDX_BASE_EN, 8'hA0, 8'h2B},
    '{4'h6, IDX_BASE_EN, 8'hA0, 8'h2B},
    '{4'h7, IDX_BASE_EN, 8'hC0, 8'h3B},
    '{4'h8, IDX_BASE_EN, 8'hC0, 8'h3B},
    '{4'hC, IDX_EXT_EN, 8'h01, 8'h43},
    '{4'hD, IDX_EXT_EN, 8'h02, 8'h4B},
    '{4'hE, IDX_EXT_EN, 8'h04, 8'h53},
    '{4'hF, IDX_EXT_EN, 8'h08, 8'h5B},
    '{4'h9, IDX_EXT_EN, 8'h10, 8'h63},
    '{4'h0, IDX_WD_PWR, 8'h20, 8'h33}};
  always #2 clk_sys_i = ~clk_sys_i;
  pia_arbiter pia_arbiter_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_pin_n_i(pins_n),
    .supply_fail_evt_i(evt[0]), .timer0_ovf_evt_i(evt[1]), .timer1_ovf_evt_i(evt[2]),
    .serial0_rx_done_i(evt[3]), .serial0_tx_done_i(evt[4]), .timer2_ovf_evt_i(evt[5]),
    .timer2_trig_evt_i(evt[6]), .serial1_rx_done_i(evt[7]), .serial1_tx_done_i(evt[8]),
    .watchdog_evt_i(evt[9]), .vector_ack_i(ack), .reti_i(reti), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .active_level_o(active_level_o));
  pia_core_model pia_core_model_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .vector_ack_o(ack), .taken_o(taken), .hold_i(hold));
  task automatic end_of_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {2'h0, idx, 2'h0};
    pwdata_i <= {24'h0, wd};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : apb
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (irq_req_o !== lvl && n < 40);
    if (n >= 40) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask : wait_irq
  task automatic pulse(input logic [9:0] m, input logic r);
    @(posedge clk_sys_i);
    evt <= m;
    reti <= r;
    @(posedge clk_sys_i);
    evt <= '0;
    reti <= 1'b0;
  endtask : pulse
  // software clears the flags not cleared on vector entry; the return closes the routine
  task automatic clear();
    foreach (regs[j]) apb(1'b1, regs[j], 8'h00);
    pulse(10'h000, 1'b1);
  endtask : clear
  task automatic take();
    hold <= 1'b0;
    wait_irq(1'b0);
    hold <= 1'b1;
  endtask : take
  initial begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    apb(1'b0, IDX_BASE_EN, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 8'h01, 8'h00);
    chk(err, 1'b1);
    foreach (rows[i]) begin
      apb(1'b1, IDX_BASE_EN, 8'h80);
      apb(1'b1, rows[i].ei, rows[i].ev);
      if (rows[i].k < 4'hA) pulse(10'h1 << rows[i].k, 1'b0);
      else pins_n[rows[i].k - 4'hA] <= 1'b0;
      wait_irq(1'b1);
      chk(irq_vector_o, rows[i].vec);
      wait_irq(1'b0);
      chk(taken, rows[i].vec);
      pins_n <= 6'h3F;
      clear();
    end
    hold <= 1'b1;
    pulse(10'h002, 1'b0);
    apb(1'b0, IDX_TCTRL, 8'h00);
    chk(rd, 32'h20);
    chk(irq_req_o, 1'b0);
    apb(1'b1, IDX_BASE_EN, 8'h82);
    wait_irq(1'b1);
    take();
    apb(1'b0, IDX_TCTRL, 8'h00);
    chk(rd, 32'h00);
    clear();
    // level mode: the flag tracks the pin both ways, with every enable off
    pins_n <= 6'h3E;
    repeat (8) @(posedge clk_sys_i);
    apb(1'b0, IDX_TCTRL, 8'h00);
    chk(rd, 32'h02);
    pins_n <= 6'h3F;
    repeat (8) @(posedge clk_sys_i);
    apb(1'b0, IDX_TCTRL, 8'h00);
    chk(rd, 32'h00);
    apb(1'b1, IDX_TCTRL, 8'h01);
    apb(1'b1, IDX_BASE_EN, 8'h81);
    pins_n <= 6'h3E;
    repeat (8) @(posedge clk_sys_i);
    pins_n <= 6'h3F;
    wait_irq(1'b1);
    chk(irq_vector_o, 8'h03);
    take();
    apb(1'b0, IDX_TCTRL, 8'h00);
    chk(rd, 32'h01);
    clear();
    apb(1'b1, IDX_BASE_EN, 8'h92);
    pulse(10'h00A, 1'b0);
    wait_irq(1'b1);
    chk(irq_vector_o, 8'h0B);
    apb(1'b1, IDX_PRIO_HIGH, 8'h10);
    apb(1'b0, IDX_PRIO_HIGH, 8'h00);
    chk(rd, 32'h10);
    chk(irq_vector_o, 8'h23);
    chk(active_level_o, 3'h2);
    apb(1'b1, IDX_WD_PWR, 8'h20);
    pulse(10'h001, 1'b0);
    repeat (4) @(posedge clk_sys_i);
    chk(irq_vector_o, 8'h33);
    take();
    repeat (4) @(posedge clk_sys_i);
    chk(irq_req_o, 1'b0);
    apb(1'b1, IDX_WD_PWR, 8'h00);
    pulse(10'h000, 1'b1);
    wait_irq(1'b1);
    chk(irq_vector_o, 8'h23);
    // mid-run reset while a request stands: it must vanish and the base enable register returns to zero
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(irq_req_o, 1'b0);
    apb(1'b0, IDX_BASE_EN, 8'h00);
    chk(rd, 32'h0);
    end_of_test();
  end
endmodule : pia_arbiter_test
`default_nettype wire
